// ===== rtl/crc_top.sv
// clock guard, oscillator control, divider and reset merging for the controller
`timescale 1ns/10ps
`default_nettype none
module crc_top
import crc_pkg::*;
#(
    parameter logic [STAB_W-1:0] STAB_CYCLES = STAB_CYCLES_DEF
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic guard_opt_i,
    input wire logic undervoltage_opt_i,
    input wire logic osc_edge_i,
    input wire logic backup_edge_i,
    input wire logic rst_pin_n_i,
    input wire logic por_i,
    input wire logic wdg_end_i,
    input wire logic undervoltage_detect_i,
    input wire logic stop_mode_i,
    output logic main_osc_en_o,
    output logic backup_low_freq_osc_o,
    output logic int_clk_tick_o,
    output logic periph_tick_o,
    output logic core_tick_o,
    output logic sys_rst_o,
    output logic io_pullup_o,
    output logic wdg_reinit_o,
    output logic init_start_o,
    output logic rst_pin_o,
    output logic rst_pin_oe_o
);
    import crc_pkg::*;

    typedef struct packed {
        logic [7:0] conv_ctrl;
        logic [DIV_SEL_W-1:0] div_sel;
        logic [GUARD_W-1:0] guard_gap;
        logic [GUARD_W-1:0] gap_cnt;
        logic [GUARD_W-1:0] miss_cnt;
        logic backup_on;
        logic [7:0] rdata;
        crc_rst_state_t st;
        logic [STAB_W-1:0] stab;
        logic int_src;
        logic sys_rst;
        logic init;
        logic wdg_reinit;
        logic main_en;
    } crc_state_t;

    crc_state_t s_reg, s_next;
    logic pin_req, por_req, uv_req, any_src, kept_edge, osc_running, clk_edge;

    // async sources assert at once and release through synchronisers
    crc_sync u_pin_sync (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(!rst_pin_n_i),
                         .req_o(pin_req));
    crc_sync u_por_sync (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(por_i),
                         .req_o(por_req));
    crc_sync u_uv_sync (.clk_i(clk_i), .nrst_i(nrst_i),
                        .req_i(undervoltage_detect_i && undervoltage_opt_i),
                        .req_o(uv_req));

    // four reset sources merged; watchdog is already synchronous
    assign any_src = pin_req || por_req || uv_req || wdg_end_i;

    // spike filter: an edge no more than the guard gap cycles after the last kept one is dropped
    assign kept_edge = osc_edge_i && s_reg.main_en
        && (!guard_opt_i || s_reg.gap_cnt >= s_reg.guard_gap);
    assign osc_running = s_reg.main_en && s_reg.miss_cnt < MISS_LIMIT;
    // backup edges take over the divider only while it runs
    assign clk_edge = s_reg.backup_on ? backup_edge_i : kept_edge;

    crc_clkdiv u_div (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .edge_i(clk_edge),
        .sel_i(s_reg.div_sel),
        .int_tick_o(int_clk_tick_o),
        .periph_tick_o(periph_tick_o),
        .core_tick_o(core_tick_o)
    );

    always_comb
    begin
        s_next = s_reg;
        s_next.init = 1'b0;
        s_next.wdg_reinit = 1'b0;
        // register writes; divider control is write-only
        if (wr_i && addr_i == ADDR_CONV_CTRL)
            s_next.conv_ctrl = wdata_i;
        if (wr_i && addr_i == ADDR_DIV_CTRL)
            s_next.div_sel = wdata_i[DIV_SEL_W-1:0];
        if (wr_i && addr_i == ADDR_GUARD_CFG)
            s_next.guard_gap = wdata_i[GUARD_W-1:0];
        // reads: unmapped and write-only addresses read zero
        s_next.rdata = 8'h00;
        if (rd_i)
        begin
            if (addr_i == ADDR_CONV_CTRL)
                s_next.rdata = s_reg.conv_ctrl;
            else if (addr_i == ADDR_GUARD_CFG)
                s_next.rdata = {4'h0, s_reg.guard_gap};
            else if (addr_i == ADDR_STATUS)
                s_next.rdata = {3'h0, s_reg.int_src, s_reg.sys_rst, osc_running,
                                s_reg.backup_on, s_reg.main_en};
        end
        // stop bit gates the main oscillator only with the guard option on; reset always restarts it
        s_next.main_en = !s_next.conv_ctrl[OSC_STOP_BIT]
            || !guard_opt_i;
        // spacing counter on kept edges, missing-edge counter on the raw oscillator
        if (kept_edge)
            s_next.gap_cnt = '0;
        else if (s_reg.gap_cnt != '1)
            s_next.gap_cnt = s_reg.gap_cnt + 4'h1;
        if (osc_edge_i && s_reg.main_en)
            s_next.miss_cnt = '0;
        else if (s_reg.miss_cnt != MISS_LIMIT)
            s_next.miss_cnt = s_reg.miss_cnt + 4'h1;
        // backup oscillator: on after missing edges, off once main runs
        if (!guard_opt_i)
            s_next.backup_on = 1'b0;
        else if (!s_reg.main_en || s_reg.miss_cnt >= MISS_LIMIT)
            s_next.backup_on = 1'b1;
        else if (osc_edge_i)
            s_next.backup_on = 1'b0;
        // reset sequencer shared by every source
        unique case (s_reg.st)
            CRC_HOLD:
            begin
                if (!any_src)
                    s_next.st = CRC_WAIT_OSC;
            end
            CRC_WAIT_OSC:
            begin
                if (osc_edge_i || s_reg.backup_on)
                begin
                    s_next.st = CRC_STAB;
                    s_next.stab = '0;
                end
            end
            CRC_STAB:
            begin
                if (s_reg.stab == STAB_CYCLES - 16'h1)
                begin
                    s_next.st = CRC_RUN;
                    s_next.sys_rst = 1'b0;
                    s_next.int_src = 1'b0;
                    s_next.init = 1'b1;
                end
                else
                    s_next.stab = s_reg.stab + 16'h1;
            end
            CRC_RUN:
            begin
            end
        endcase
        // any source restarts the whole sequence and wins over progress
        if (any_src)
        begin
            s_next.st = CRC_HOLD;
            s_next.sys_rst = 1'b1;
            s_next.stab = '0;
            s_next.init = 1'b0;
            s_next.conv_ctrl = CONV_CTRL_RESET;
            s_next.div_sel = DIV_CTRL_RESET[DIV_SEL_W-1:0];
            s_next.main_en = 1'b1;
            if (wdg_end_i)
                s_next.wdg_reinit = 1'b1;
            if (por_req || uv_req || wdg_end_i)
                s_next.int_src = 1'b1;
        end
    end

    // single state register; reset begins in the power-on hold state
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '0;
            s_reg.conv_ctrl <= CONV_CTRL_RESET;
            s_reg.guard_gap <= GUARD_MIN_GAP_DEF;
            s_reg.st <= CRC_HOLD;
            s_reg.sys_rst <= 1'b1;
            s_reg.int_src <= 1'b1;
            s_reg.main_en <= 1'b1;
        end
        else
            s_reg <= s_next;
    end

    assign rdata_o = s_reg.rdata;
    assign main_osc_en_o = s_reg.main_en;
    assign backup_low_freq_osc_o = s_reg.backup_on;
    assign sys_rst_o = s_reg.sys_rst;
    assign io_pullup_o = s_reg.sys_rst; // I/O pulled-up inputs during reset
    assign wdg_reinit_o = s_reg.wdg_reinit;
    assign init_start_o = s_reg.init;
    // open drain: only ever drives low, while an internal source holds reset
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = s_reg.int_src;
endmodule
`default_nettype wire

// ===== rtl/crc_pkg.sv
// package: constants, register map and state types for the clock and reset control block
// Notes on behaviour
// - main oscillator runs while stop bit 2 of converter control is zero.
// - guard features exist only when the guard option is strapped on.
// - with guard on, excess oscillator edges are dropped to respect frequency limit.
// - with guard on, backup oscillator starts after first missing main edge.
// - divider control is write-only, resets to zero, bits 7..2 unused.
// - divider select 00 divides by 1, 01 by 2, 10 and 11 by 4.
// - reset comes from pin, power-on, watchdog end of count, undervoltage.
// - internal reset extends pin reset by a delay, short pulses give full reset.
// - pin low is honoured in run, wait, stop and holds reset while low.
// - pin reset in run or wait halts, pulls up I/O, restarts oscillator.
// - pin reset in stop starts oscillator, pulls up I/O, then initialises.
// - power-on holds reset, waits for oscillator, delays, then initialises.
// - watchdog end of count asserts reset which also reinitialises watchdog.
// - watchdog reset restarts exactly like pin reset with full delay.
// - undervoltage holds static reset while supply is below its reference.
// - internal reset sources drive the reset pin low.
// - setting the stop bit with guard on starts the backup oscillator.
// - main oscillator restarts when stop bit clears or on any reset.
// - backup oscillator stops as soon as the main oscillator runs; here it stops on the next main edge after osc_running is set.
// - internal clock divided by 12 for peripherals and 13 for the core.
package crc_pkg;
    localparam logic [7:0] ADDR_CONV_CTRL = 8'hD1;
    localparam logic [7:0] ADDR_DIV_CTRL = 8'hDC;
    localparam logic [7:0] ADDR_GUARD_CFG = 8'hF0; // extra control of own placement
    localparam logic [7:0] ADDR_STATUS = 8'hF1;
    localparam logic [7:0] CONV_CTRL_RESET = 8'h40;
    localparam logic [7:0] DIV_CTRL_RESET = 8'h00;
    localparam int OSC_STOP_BIT = 2;
    localparam int DIV_SEL_W = 2;
    localparam logic [1:0] DIV_SEL_BY1 = 2'h0;
    localparam logic [1:0] DIV_SEL_BY2 = 2'h1;
    localparam logic [3:0] PERIPH_DIV = 4'hC;
    localparam logic [3:0] CORE_DIV = 4'hD;
    localparam int GUARD_W = 4;
    localparam logic [3:0] GUARD_MIN_GAP_DEF = 4'h2; // clk cycles after a kept edge in which further edges are dropped
    localparam logic [3:0] MISS_LIMIT = 4'h8; // cycles without edge = missing edge
    localparam int STAB_W = 16;
    localparam logic [15:0] STAB_CYCLES_DEF = 16'h1000;
    typedef enum logic [1:0] {CRC_HOLD, CRC_WAIT_OSC, CRC_STAB, CRC_RUN} crc_rst_state_t;
endpackage

// ===== rtl/crc_sync.sv
// two-flop release synchroniser for asynchronous reset requests
`timescale 1ns/10ps
`default_nettype none
module crc_sync
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic req_i,
    output logic req_o
);
    logic [1:0] sync_reg;
    // assert at once, release after two edges so deassertion is clean
    always_ff @(posedge clk_i or negedge nrst_i or posedge req_i)
    begin
        if (!nrst_i || req_i)
            sync_reg <= 2'h3;
        else
            sync_reg <= {sync_reg[0], 1'b0};
    end
    assign req_o = sync_reg[1];
endmodule
`default_nettype wire

// ===== rtl/crc_clkdiv.sv
// divider from oscillator edges: select ratio then 12 and 13 enable pulses
`timescale 1ns/10ps
`default_nettype none
module crc_clkdiv
import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic edge_i,
    input wire logic [DIV_SEL_W-1:0] sel_i,
    output logic int_tick_o,
    output logic periph_tick_o,
    output logic core_tick_o
);
    typedef struct packed {
        logic [1:0] pre;
        logic [3:0] per;
        logic [3:0] core;
        logic it;
        logic pt;
        logic ct;
    } crc_div_st_t;
    crc_div_st_t s_reg, s_next;

    // ratio from the select code; both upper codes mean four
    function automatic logic [1:0] div_last(input logic [1:0] sel);
        unique case (sel)
            DIV_SEL_BY1: div_last = 2'h0;
            DIV_SEL_BY2: div_last = 2'h1;
            default: div_last = 2'h3;
        endcase
    endfunction

    // wrap test for the modulo counters
    function automatic logic at_end(input logic [3:0] cnt, input logic [3:0] div);
        at_end = (cnt == div - 4'h1);
    endfunction

    always_comb
    begin
        s_next = s_reg;
        s_next.it = 1'b0;
        s_next.pt = 1'b0;
        s_next.ct = 1'b0;
        if (edge_i)
        begin
            if (s_reg.pre >= div_last(sel_i))
            begin
                s_next.pre = 2'h0;
                s_next.it = 1'b1;
                s_next.per = at_end(s_reg.per, PERIPH_DIV) ? 4'h0 : s_reg.per + 4'h1;
                s_next.core = at_end(s_reg.core, CORE_DIV) ? 4'h0 : s_reg.core + 4'h1;
                s_next.pt = at_end(s_reg.per, PERIPH_DIV);
                s_next.ct = at_end(s_reg.core, CORE_DIV);
            end
            else
                s_next.pre = s_reg.pre + 2'h1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign int_tick_o = s_reg.it;
    assign periph_tick_o = s_reg.pt;
    assign core_tick_o = s_reg.ct;
endmodule
`default_nettype wire

// ===== dv/crc_top_sva.sv
// checker: port-level properties of the clock and reset control block
`timescale 1ns/10ps
`default_nettype none
module crc_top_sva
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic guard_opt_i,
    input wire logic rst_pin_n_i,
    input wire logic wdg_end_i,
    input wire logic main_osc_en_o,
    input wire logic backup_low_freq_osc_o,
    input wire logic sys_rst_o,
    input wire logic io_pullup_o,
    input wire logic wdg_reinit_o,
    input wire logic init_start_o,
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    // a watchdog trip while running, then the restart it must cause
    sequence wdg_trip_s;
        wdg_end_i && !sys_rst_o;
    endsequence
    sequence wdg_reset_s;
        ##[1:4] sys_rst_o;
    endsequence
    a_pin_low_only: assert property (rst_pin_o == 1'b0)
        else $error("reset pin driven to a high level");
    a_wdg_pin_drive: assert property (wdg_trip_s |-> ##[1:4] rst_pin_oe_o)
        else $error("watchdog reset left the reset pin undriven");
    a_pullup_follows: assert property (io_pullup_o == sys_rst_o)
        else $error("pull-up state differs from internal reset");
    a_pin_holds: assert property (!rst_pin_n_i [*3] |-> sys_rst_o)
        else $error("reset released while pin still low");
    a_init_single: assert property (init_start_o |=> !init_start_o)
        else $error("init start longer than one cycle");
    a_init_releases: assert property (init_start_o |-> ##[0:1] !sys_rst_o)
        else $error("reset still active after init start");
    a_wdg_reinit: assert property (wdg_trip_s |-> ##[1:4] wdg_reinit_o)
        else $error("watchdog reset without counter reinit");
    a_wdg_restart: assert property (wdg_trip_s |-> wdg_reset_s)
        else $error("watchdog end of count gave no reset");
    a_guard_off_main: assert property (!guard_opt_i |-> main_osc_en_o)
        else $error("main oscillator stopped without guard option");
    a_guard_off_bak: assert property (!guard_opt_i |-> !backup_low_freq_osc_o)
        else $error("backup oscillator on without guard option");
    a_reset_osc_on: assert property ($rose(sys_rst_o) |-> ##[0:2] main_osc_en_o)
        else $error("reset did not restart the main oscillator");
endmodule
bind crc_top crc_top_sva crc_top_sva_i (.clk_i, .nrst_i, .guard_opt_i, .rst_pin_n_i,
    .wdg_end_i, .main_osc_en_o, .backup_low_freq_osc_o, .sys_rst_o, .io_pullup_o,
    .wdg_reinit_o, .init_start_o, .rst_pin_o, .rst_pin_oe_o);
`default_nettype wire

// ===== dv/crc_osc_model.sv
// stand-in for the main crystal and the backup oscillator
`timescale 1ns/10ps
`default_nettype none
module crc_osc_model
(
    input wire logic clk_i,
    input wire logic main_en_i,
    input wire logic backup_en_i,
    input wire logic nrst_i,
    input wire logic burst_i,
    input wire logic dead_i,
    output logic osc_edge_o,
    output logic backup_edge_o
);
    logic [3:0] phase_reg;
    // a stopped or dead crystal gives no edges; burst mimics spikes on every cycle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            phase_reg <= 4'h0;
            osc_edge_o <= 1'b0;
            backup_edge_o <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_reg + 4'h1;
            osc_edge_o <= main_en_i && !dead_i
                && (burst_i || phase_reg[1:0] == 2'h0);
            backup_edge_o <= backup_en_i && phase_reg == 4'h0;
        end
    end
endmodule
`default_nettype wire

// ===== dv/crc_top_bench.sv
// self-checking bench for the clock and reset control block
`timescale 1ns/10ps
`default_nettype none
module crc_top_bench;
    import crc_pkg::*;
    localparam logic [15:0] STAB = 16'h0008; // short delay keeps the run brief
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic guard_opt_i = 1'b1;
    logic undervoltage_opt_i = 1'b1;
    logic rst_pin_n_i = 1'b1;
    logic por_i = 1'b0;
    logic wdg_end_i = 1'b0;
    logic undervoltage_detect_i = 1'b0;
    logic stop_mode_i = 1'b0;
    logic burst = 1'b0;
    logic dead = 1'b0;
    logic osc_edge, backup_edge, main_osc_en_o, backup_low_freq_osc_o, int_clk_tick_o;
    logic periph_tick_o, core_tick_o, sys_rst_o, io_pullup_o, wdg_reinit_o, init_start_o;
    logic rst_pin_o, rst_pin_oe_o;
    logic [7:0] rdata_o, v;
    int bad_count = 0;
    int total_checks = 0;
    int n, ti;
    int kind[6] = '{0, 0, 0, 1, 2, 3}; // pin, pin short, pin in stop, power-on, watchdog, supply
    int len[6] = '{30, 1, 30, 30, 1, 30};
    crc_top #(.STAB_CYCLES(STAB)) crc_top_i (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .guard_opt_i, .undervoltage_opt_i, .osc_edge_i(osc_edge),
        .backup_edge_i(backup_edge), .rst_pin_n_i, .por_i, .wdg_end_i, .undervoltage_detect_i,
        .stop_mode_i, .main_osc_en_o, .backup_low_freq_osc_o, .int_clk_tick_o, .periph_tick_o,
        .core_tick_o, .sys_rst_o, .io_pullup_o, .wdg_reinit_o, .init_start_o, .rst_pin_o,
        .rst_pin_oe_o);
    crc_osc_model crc_osc_model_i (.clk_i, .nrst_i, .main_en_i(main_osc_en_o),
        .backup_en_i(backup_low_freq_osc_o), .burst_i(burst), .dead_i(dead),
        .osc_edge_o(osc_edge), .backup_edge_o(backup_edge));
    initial
    begin
        forever #2 clk_i = ~clk_i;
    end
    task automatic conclude;
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        conclude();
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask
    task automatic run(input int cyc);
        ti = 0;
        repeat (cyc)
        begin
            @(posedge clk_i);
            #1;
            ti += int'(int_clk_tick_o === 1'b1);
        end
    endtask
    // counts inner events between two pulses: w 0 periph, 1 core, 2 osc edges per int tick
    task automatic span(input int w, output int ticks);
        int hits;
        hits = 0;
        ticks = 0;
        for (int k = 0; k < 3000 && hits < 2; k++)
        begin
            @(posedge clk_i);
            #1;
            if (hits == 1 && (w == 2 ? osc_edge : int_clk_tick_o) === 1'b1)
                ticks++;
            if ((w == 0 ? periph_tick_o : w == 1 ? core_tick_o : int_clk_tick_o) === 1'b1)
                hits++;
        end
        if (hits < 2)
            hang();
    endtask
    task automatic wait_init(output int cyc);
        cyc = 0;
        while (init_start_o !== 1'b1)
        begin
            @(posedge clk_i);
            #1;
            cyc++;
            if (cyc > 500)
                hang();
        end
    endtask
    initial
    begin
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        wait_init(n);
        check("power-up delay", 16'(n >= STAB), 16'h1);
        rd(ADDR_CONV_CTRL);
        check("conv ctrl reset", 16'(v), 16'(CONV_CTRL_RESET));
        rd(ADDR_DIV_CTRL);
        check("div ctrl readback", 16'(v), 16'h0);
        rd(8'h55);
        check("unmapped read", 16'(v), 16'h0);
        // the bench holds its own image of the write-only divider setting
        for (int s = 0; s < 4; s++)
        begin
            wr(ADDR_DIV_CTRL, 8'(s));
            span(2, n);
            check("divider ratio", 16'(n), 16'(s == 0 ? 1 : s == 1 ? 2 : 4));
        end
        wr(ADDR_DIV_CTRL, DIV_CTRL_RESET);
        span(0, n);
        check("periph ratio", 16'(n), 16'(PERIPH_DIV));
        span(1, n);
        check("core ratio", 16'(n), 16'(CORE_DIV));
        burst <= 1'b1;
        run(40);
        // kept edges are at least gap plus one cycles apart
        check("spike limit", 16'(ti * (int'(GUARD_MIN_GAP_DEF) + 1) <= 40
            + int'(GUARD_MIN_GAP_DEF) && ti > 0), 16'h1);
        burst <= 1'b0;
        // a failed crystal: edges stop while the main oscillator stays enabled
        dead <= 1'b1;
        run(20);
        check("backup on missing edge", 16'(backup_low_freq_osc_o), 16'h1);
        rd(ADDR_STATUS);
        check("status word", 16'(v), 16'h3);
        dead <= 1'b0;
        run(40);
        check("backup off on edges", 16'(backup_low_freq_osc_o), 16'h0);
        wr(ADDR_CONV_CTRL, 8'h44);
        rd(ADDR_CONV_CTRL);
        check("stop bit readback", 16'(v), 16'h44);
        check("main osc stopped", 16'(main_osc_en_o), 16'h0);
        run(20);
        check("backup started", 16'(backup_low_freq_osc_o), 16'h1);
        wr(ADDR_CONV_CTRL, 8'h40);
        run(40);
        check("main osc back", 16'(main_osc_en_o), 16'h1);
        check("backup stopped", 16'(backup_low_freq_osc_o), 16'h0);
        // every source, each entered with the main oscillator stopped
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_CONV_CTRL, 8'h44);
            stop_mode_i <= i == 2;
            rst_pin_n_i <= kind[i] != 0;
            por_i <= kind[i] == 1;
            wdg_end_i <= kind[i] == 2;
            undervoltage_detect_i <= kind[i] == 3;
            repeat (len[i]) @(posedge clk_i);
            rst_pin_n_i <= 1'b1;
            por_i <= 1'b0;
            wdg_end_i <= 1'b0;
            undervoltage_detect_i <= 1'b0;
            // look once the edge that took the source has settled
            #1;
            check("held by source", 16'(sys_rst_o), 16'h1);
            check("pin driven", 16'(rst_pin_oe_o), 16'(kind[i] != 0));
            repeat (3) @(posedge clk_i);
            #1;
            check("reset extended", 16'(sys_rst_o), 16'h1);
            wait_init(n);
            check("restart delay", 16'(n + 3 >= STAB), 16'h1);
            rd(ADDR_CONV_CTRL);
            check("stop bit cleared", 16'(v), 16'(CONV_CTRL_RESET));
        end
        // guard off, as serial timing needs: stop bit has no effect
        @(posedge clk_i);
        guard_opt_i <= 1'b0;
        wr(ADDR_CONV_CTRL, 8'h44);
        run(20);
        check("no guard main", 16'(main_osc_en_o), 16'h1);
        check("no guard backup", 16'(backup_low_freq_osc_o), 16'h0);
        conclude();
    end
endmodule
`default_nettype wire
